// File: design/ptp_unit_pkg.sv
// constants and register map of the event unit index and status block
package ptp_unit_pkg;
   localparam int FIRE_UNITS = 3;
   localparam int STAMP_UNITS = 2;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFF_INDEX = 12'h520;
   localparam logic [ADDR_W-1:0] OFF_FIRE_STAT = 12'h524;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 12'h528;
   localparam logic [ADDR_W-1:0] OFF_UNIT_CTRL = 12'h52c;
   localparam logic [ADDR_W-1:0] OFF_UNIT_LAST = 12'h5b3;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 12'h5c0;
   localparam int STAMP_SEL_BIT = 8;
   localparam int FIRE_SEL_LSB = 0;
   localparam int FIRE_SEL_W = 2;
   localparam logic [FIRE_SEL_W-1:0] FIRE_SEL_RSVD = 2'h3;
   localparam logic STAMP_SEL_RST = 1'h0;
   localparam logic [FIRE_SEL_W-1:0] FIRE_SEL_RST = 2'h0;
   localparam int FIRE_ERR_LSB = 16;
   localparam int FIRE_DONE_LSB = 0;
   localparam int IRQ_FIRE_LSB = 16;
   localparam int IRQ_STAMP_LSB = 0;
   localparam int CTRL_FIRE_EN_BIT = 3;
   localparam int CTRL_STAMP_IRQ_BIT = 5;
   localparam int HTRANS_ACT_BIT = 1;
   localparam logic HRESP_OKAY = 1'h0;
endpackage : ptp_unit_pkg

// File: design/reg_req_if.sv
// register request carrier between bus port and register logic
`timescale 1ns/1ps
`default_nettype none
interface reg_req_if;
   logic wr;
   logic rd;
   logic [ptp_unit_pkg::ADDR_W-1:0] addr;
   logic [ptp_unit_pkg::DATA_W-1:0] wdata;
   logic [ptp_unit_pkg::DATA_W-1:0] rdata;
   modport port (output wr, output rd, output addr, output wdata, input rdata);
   modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface : reg_req_if
`default_nettype wire

// File: design/ahb_reg_port.sv
// ahb-lite slave front end producing register strobes
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_port
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   reg_req_if.port bus
);
   typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_RD_WAIT, ST_RD_DONE} phase_e;
   typedef struct packed {
      phase_e phase;
      logic [ptp_unit_pkg::ADDR_W-1:0] addr;
      logic [ptp_unit_pkg::DATA_W-1:0] rdata;
   } port_s;
   port_s s;
   port_s next_s;
   logic take;

   always_comb
   begin
      take = hsel_i && hready_i && htrans_i[ptp_unit_pkg::HTRANS_ACT_BIT];
      next_s = s;
      case (s.phase)
         ST_RD_WAIT:
         begin
            next_s.rdata = bus.rdata;
            next_s.phase = ST_RD_DONE;
         end
         default:
         begin
            next_s.phase = ST_IDLE;
            if (take)
            begin
               next_s.addr = haddr_i[ptp_unit_pkg::ADDR_W-1:0];
               next_s.phase = hwrite_i ? ST_WRITE : ST_RD_WAIT;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s <= '{phase: ST_IDLE, addr: '0, rdata: '0};
      else
         s <= next_s;
   end

   // one wait state on reads, none on writes
   assign bus.wr = s.phase == ST_WRITE;
   assign bus.rd = s.phase == ST_RD_WAIT;
   assign bus.addr = s.addr;
   assign bus.wdata = hwdata_i;
   assign hreadyout_o = s.phase != ST_RD_WAIT;
   assign hrdata_o = s.rdata;
   assign hresp_o = ptp_unit_pkg::HRESP_OKAY;
endmodule : ahb_reg_port
`default_nettype wire

// File: design/ptp_unit_index_gpio_status.sv
// event unit index, trigger status and interrupt status registers
`timescale 1ns/1ps
`default_nettype none
module ptp_unit_index_gpio_status
(
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic [ptp_unit_pkg::FIRE_UNITS-1:0] FIRE_LATE_I,
   input wire logic [ptp_unit_pkg::FIRE_UNITS-1:0] FIRE_DONE_I,
   input wire logic [ptp_unit_pkg::FIRE_UNITS-1:0] FIRE_NOTIFY_ON_I,
   input wire logic [ptp_unit_pkg::STAMP_UNITS-1:0] STAMP_EVENT_I,
   output logic UNIT_WR_O,
   output logic UNIT_RD_O,
   output logic [ptp_unit_pkg::ADDR_W-1:0] UNIT_ADDR_O,
   output logic [31:0] UNIT_WDATA_O,
   input wire logic [31:0] UNIT_RDATA_I,
   output logic STAMP_SEL_O,
   output logic [ptp_unit_pkg::FIRE_SEL_W-1:0] FIRE_SEL_O,
   output logic GLOBAL_STATUS_O,
   output logic IRQ_O
);
   localparam int NF = ptp_unit_pkg::FIRE_UNITS;
   localparam int NS = ptp_unit_pkg::STAMP_UNITS;

   typedef struct packed {
      logic stamp_sel;
      logic [ptp_unit_pkg::FIRE_SEL_W-1:0] fire_sel;
      logic [NF-1:0] fire_error;
      logic [NF-1:0] fire_done;
      logic [NF-1:0] irq_fire;
      logic [NS-1:0] irq_stamp;
      logic [NF-1:0] mask_fire;
      logic [NS-1:0] mask_stamp;
      logic [NS-1:0] stamp_irq_on;
   } regs_s;

   regs_s s;
   regs_s next_s;
   reg_req_if bus ();

   logic idx_hit;
   logic st0_hit;
   logic st1_hit;
   logic mask_hit;
   logic unit_hit;
   logic ctrl_wr;
   logic [NF-1:0] late_hit;
   logic [NF-1:0] done_hit;
   logic [NF-1:0] err_clr;
   logic [NF-1:0] done_clr;
   logic [NF-1:0] irqf_clr;
   logic [NS-1:0] stamp_hit;
   logic [NS-1:0] irqs_clr;
   logic [31:0] rd;

   ahb_reg_port i_ahb_reg_port
   (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .hsel_i(HSEL_I),
      .haddr_i(HADDR_I),
      .htrans_i(HTRANS_I),
      .hwrite_i(HWRITE_I),
      .hsize_i(HSIZE_I),
      .hwdata_i(HWDATA_I),
      .hready_i(HREADY_I),
      .hrdata_o(HRDATA_O),
      .hreadyout_o(HREADYOUT_O),
      .hresp_o(HRESP_O),
      .bus(bus.port)
   );

   // address decode
   assign idx_hit = bus.addr == ptp_unit_pkg::OFF_INDEX;
   assign st0_hit = bus.addr == ptp_unit_pkg::OFF_FIRE_STAT;
   assign st1_hit = bus.addr == ptp_unit_pkg::OFF_IRQ_STAT;
   assign mask_hit = bus.addr == ptp_unit_pkg::OFF_IRQ_MASK;
   assign unit_hit = bus.addr >= ptp_unit_pkg::OFF_UNIT_CTRL
      && bus.addr <= ptp_unit_pkg::OFF_UNIT_LAST
      && s.fire_sel != ptp_unit_pkg::FIRE_SEL_RSVD;
   assign ctrl_wr = bus.wr && unit_hit
      && bus.addr == ptp_unit_pkg::OFF_UNIT_CTRL;

   // per trigger and timestamp unit events and clears
   genvar i;
   generate
      for (i = 0; i < NF; i++)
      begin : g_fire
         assign late_hit[i] = FIRE_LATE_I[i] && FIRE_NOTIFY_ON_I[i];
         assign done_hit[i] = FIRE_DONE_I[i] && FIRE_NOTIFY_ON_I[i];
         assign err_clr[i] = ctrl_wr && s.fire_sel == 2'(i)
            && !bus.wdata[ptp_unit_pkg::CTRL_FIRE_EN_BIT];
         assign done_clr[i] = bus.wr && st0_hit
            && bus.wdata[ptp_unit_pkg::FIRE_DONE_LSB+i];
         assign irqf_clr[i] = bus.wr && st1_hit
            && bus.wdata[ptp_unit_pkg::IRQ_FIRE_LSB+i];
      end
      for (i = 0; i < NS; i++)
      begin : g_stamp
         assign stamp_hit[i] = STAMP_EVENT_I[i] && s.stamp_irq_on[i];
         assign irqs_clr[i] = bus.wr && st1_hit
            && bus.wdata[ptp_unit_pkg::IRQ_STAMP_LSB+i];
      end
   endgenerate

   always_comb
   begin
      next_s = s;
      if (bus.wr && idx_hit)
      begin
         next_s.stamp_sel = bus.wdata[ptp_unit_pkg::STAMP_SEL_BIT];
         next_s.fire_sel = bus.wdata[ptp_unit_pkg::FIRE_SEL_LSB +:
            ptp_unit_pkg::FIRE_SEL_W];
      end
      if (bus.wr && mask_hit)
      begin
         next_s.mask_fire = bus.wdata[ptp_unit_pkg::IRQ_FIRE_LSB +: NF];
         next_s.mask_stamp = bus.wdata[ptp_unit_pkg::IRQ_STAMP_LSB +: NS];
      end
      if (ctrl_wr)
         next_s.stamp_irq_on[s.stamp_sel] =
            bus.wdata[ptp_unit_pkg::CTRL_STAMP_IRQ_BIT];
      // a set in the same cycle wins over the clear
      next_s.fire_error = (s.fire_error & ~err_clr) | late_hit;
      next_s.fire_done = (s.fire_done & ~done_clr) | done_hit;
      next_s.irq_fire = (s.irq_fire & ~irqf_clr) | late_hit | done_hit;
      next_s.irq_stamp = (s.irq_stamp & ~irqs_clr) | stamp_hit;
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         s <= '0;
         s.stamp_sel <= ptp_unit_pkg::STAMP_SEL_RST;
         s.fire_sel <= ptp_unit_pkg::FIRE_SEL_RST;
      end
      else
         s <= next_s;
   end

   // read mux, reserved bits zero
   always_comb
   begin
      rd = '0;
      if (idx_hit)
      begin
         rd[ptp_unit_pkg::STAMP_SEL_BIT] = s.stamp_sel;
         rd[ptp_unit_pkg::FIRE_SEL_LSB +: ptp_unit_pkg::FIRE_SEL_W] =
            s.fire_sel;
      end
      else if (st0_hit)
      begin
         rd[ptp_unit_pkg::FIRE_ERR_LSB +: NF] = s.fire_error;
         rd[ptp_unit_pkg::FIRE_DONE_LSB +: NF] = s.fire_done;
      end
      else if (st1_hit)
      begin
         rd[ptp_unit_pkg::IRQ_FIRE_LSB +: NF] = s.irq_fire;
         rd[ptp_unit_pkg::IRQ_STAMP_LSB +: NS] = s.irq_stamp;
      end
      else if (mask_hit)
      begin
         rd[ptp_unit_pkg::IRQ_FIRE_LSB +: NF] = s.mask_fire;
         rd[ptp_unit_pkg::IRQ_STAMP_LSB +: NS] = s.mask_stamp;
      end
      else if (unit_hit)
      begin
         rd = UNIT_RDATA_I;
         if (bus.addr == ptp_unit_pkg::OFF_UNIT_CTRL)
            rd[ptp_unit_pkg::CTRL_STAMP_IRQ_BIT] =
               s.stamp_irq_on[s.stamp_sel];
      end
   end
   assign bus.rdata = rd;

   // indexed unit access path
   assign UNIT_WR_O = bus.wr && unit_hit;
   assign UNIT_RD_O = bus.rd && unit_hit;
   assign UNIT_ADDR_O = bus.addr;
   assign UNIT_WDATA_O = bus.wdata;
   assign STAMP_SEL_O = s.stamp_sel;
   assign FIRE_SEL_O = s.fire_sel;
   assign GLOBAL_STATUS_O = |{s.irq_fire, s.irq_stamp};
   assign IRQ_O = |{s.irq_fire & s.mask_fire, s.irq_stamp & s.mask_stamp};

   chk_index_stamp_sel: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.wr && idx_hit |=> STAMP_SEL_O == $past(bus.wdata[8]))
      else $error("stamp select not taken from index write");

   chk_index_fire_sel: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.wr && idx_hit |=> FIRE_SEL_O == $past(bus.wdata[1:0]))
      else $error("trigger select not taken from index write");

   chk_reserved_code_quiet: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      FIRE_SEL_O == 2'h3 |-> !UNIT_WR_O && !UNIT_RD_O)
      else $error("unit access under reserved trigger code");

   chk_error_flag_set: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      late_hit != 3'h0 |=> (s.fire_error & $past(late_hit)) == $past(late_hit))
      else $error("trigger error flag not set");

   chk_error_enable_clear: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      err_clr != 3'h0 && late_hit == 3'h0 |=> (s.fire_error & $past(err_clr))
         == 3'h0)
      else $error("trigger error flag not cleared by enable write");

   chk_done_flag_set: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      done_hit != 3'h0 |=> ##1 (s.fire_done & $past(done_hit, 2)) != 3'h0
         || $past(done_clr) != 3'h0)
      else $error("trigger done flag lost");

   chk_fire_irq_raise: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (late_hit | done_hit) != 3'h0 |=> GLOBAL_STATUS_O && s.irq_fire != 3'h0)
      else $error("trigger event did not raise status");

   chk_stamp_irq_gate: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      STAMP_EVENT_I != 2'h0 && s.stamp_irq_on == 2'h0 && s.irq_stamp == 2'h0
         |=> s.irq_stamp == 2'h0)
      else $error("disabled timestamp unit raised status");

   chk_status_w1c: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.wr && st1_hit && bus.wdata == 32'hffffffff && STAMP_EVENT_I == 2'h0
         && FIRE_LATE_I == 3'h0 && FIRE_DONE_I == 3'h0
         |=> !GLOBAL_STATUS_O)
      else $error("interrupt status not cleared by write");

   chk_irq_masked: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      s.mask_fire == 3'h0 && s.mask_stamp == 2'h0 |-> !IRQ_O)
      else $error("interrupt line high while all masked");

   chk_route_write: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.wr && bus.addr >= ptp_unit_pkg::OFF_UNIT_CTRL
         && bus.addr <= ptp_unit_pkg::OFF_UNIT_LAST
         && FIRE_SEL_O != ptp_unit_pkg::FIRE_SEL_RSVD
         |-> UNIT_WR_O && UNIT_ADDR_O == bus.addr)
      else $error("indexed write not routed to selected units");

   chk_route_read: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.rd && bus.addr >= ptp_unit_pkg::OFF_UNIT_CTRL
         && bus.addr <= ptp_unit_pkg::OFF_UNIT_LAST
         && FIRE_SEL_O != ptp_unit_pkg::FIRE_SEL_RSVD
         |-> UNIT_RD_O && UNIT_ADDR_O == bus.addr)
      else $error("indexed read not routed to selected units");

   chk_strobe_in_range: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      UNIT_WR_O || UNIT_RD_O |-> UNIT_ADDR_O >= ptp_unit_pkg::OFF_UNIT_CTRL
         && UNIT_ADDR_O <= ptp_unit_pkg::OFF_UNIT_LAST)
      else $error("unit strobe outside indexed range");

   chk_error_needs_event: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (s.fire_error & ~$past(s.fire_error)
         & ~$past(FIRE_LATE_I & FIRE_NOTIFY_ON_I)) == 3'h0)
      else $error("trigger error flag set without late event");

   chk_error_holds: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      ($past(s.fire_error) & ~s.fire_error) != 3'h0
         |-> $past(bus.wr && bus.addr == ptp_unit_pkg::OFF_UNIT_CTRL
         && !bus.wdata[ptp_unit_pkg::CTRL_FIRE_EN_BIT]))
      else $error("trigger error flag cleared without enable write");

   chk_done_needs_event: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (s.fire_done & ~$past(s.fire_done)
         & ~$past(FIRE_DONE_I & FIRE_NOTIFY_ON_I)) == 3'h0)
      else $error("trigger done flag set without done event");

   chk_done_w1c: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.wr && st0_hit && done_hit == 3'h0 |=> (s.fire_done
         & $past(bus.wdata[ptp_unit_pkg::FIRE_DONE_LSB +: NF])) == 3'h0)
      else $error("trigger done flag not cleared by write one");

   chk_fire_irq_needs_event: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (s.irq_fire & ~$past(s.irq_fire)
         & ~$past((FIRE_LATE_I | FIRE_DONE_I) & FIRE_NOTIFY_ON_I)) == 3'h0)
      else $error("trigger interrupt status set without event");

   chk_stamp_irq_needs_event: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (s.irq_stamp & ~$past(s.irq_stamp)
         & ~$past(STAMP_EVENT_I & s.stamp_irq_on)) == 2'h0)
      else $error("timestamp interrupt status set without enabled event");

   chk_global_or: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      GLOBAL_STATUS_O == (s.irq_fire != 3'h0 || s.irq_stamp != 2'h0))
      else $error("global status differs from status bits");

   chk_status_clear_by_write: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      ($past(s.irq_fire) & ~s.irq_fire) != 3'h0
         || ($past(s.irq_stamp) & ~s.irq_stamp) != 2'h0
         |-> $past(bus.wr && st1_hit))
      else $error("interrupt status cleared without status write");

   chk_stamp_enable_index: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      ctrl_wr |=> s.stamp_irq_on[$past(s.stamp_sel)]
         == $past(bus.wdata[ptp_unit_pkg::CTRL_STAMP_IRQ_BIT]))
      else $error("timestamp interrupt enable not written to selected unit");

   chk_index_rsvd_zero: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.rd && idx_hit |=> (HRDATA_O & 32'hfffffefc) == 32'h0)
      else $error("reserved index bits read nonzero");

   chk_fire_stat_rsvd_zero: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.rd && st0_hit |=> (HRDATA_O & 32'hfff8fff8) == 32'h0)
      else $error("reserved trigger status bits read nonzero");

   chk_irq_stat_rsvd_zero: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.rd && st1_hit |=> (HRDATA_O & 32'hfff8fffc) == 32'h0)
      else $error("reserved interrupt status bits read nonzero");

   chk_unmapped_read_zero: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      bus.rd && !idx_hit && !st0_hit && !st1_hit && !mask_hit && !unit_hit
         |=> HRDATA_O == 32'h0)
      else $error("unmapped or blocked read returned data");

   chk_irq_unmasked: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_N_I)
      (s.irq_fire & s.mask_fire) != 3'h0
         || (s.irq_stamp & s.mask_stamp) != 2'h0 |-> IRQ_O)
      else $error("interrupt line low with unmasked status set");
endmodule : ptp_unit_index_gpio_status
`default_nettype wire

// File: tb/ptp_unit_index_gpio_status_bench.sv
// register level testbench of the event unit index and status block
`timescale 1ns/1ps
`default_nettype none
module ptp_unit_index_gpio_status_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [2:0] fire_late = 3'h0;
   logic [2:0] fire_done = 3'h0;
   logic [2:0] fire_notify = 3'h3;
   logic [1:0] stamp_ev = 2'h0;
   logic unit_wr;
   logic unit_rd;
   logic [11:0] unit_addr;
   logic [31:0] unit_wdata;
   logic [31:0] unit_rdata = 32'h0000c300;
   logic stamp_sel;
   logic [1:0] fire_sel;
   logic global_status;
   logic irq;
   logic [31:0] last_wdata = 32'h0;
   logic [11:0] last_addr = 12'h0;
   int mismatches = 0;
   int compares = 0;
   int cycles = 0;
   int wr_cnt = 0;
   int rd_cnt = 0;

   ptp_unit_index_gpio_status i_ptp_unit_index_gpio_status
   (
      .CLK_SYS_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
      .HWDATA_I(hwdata), .HREADY_I(hreadyout), .HRDATA_O(hrdata),
      .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .FIRE_LATE_I(fire_late),
      .FIRE_DONE_I(fire_done), .FIRE_NOTIFY_ON_I(fire_notify),
      .STAMP_EVENT_I(stamp_ev), .UNIT_WR_O(unit_wr), .UNIT_RD_O(unit_rd),
      .UNIT_ADDR_O(unit_addr), .UNIT_WDATA_O(unit_wdata),
      .UNIT_RDATA_I(unit_rdata), .STAMP_SEL_O(stamp_sel),
      .FIRE_SEL_O(fire_sel), .GLOBAL_STATUS_O(global_status), .IRQ_O(irq)
   );

   initial
   begin
      forever #4 clk = ~clk;
   end

   task automatic conclude;
      if (mismatches == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk32

   task automatic chk1(input logic exp);
      @(negedge clk);
      compares++;
      if (irq !== exp)
      begin
         mismatches++;
         $display("Error at %0t: irq %h expected %h", $time, irq, exp);
      end
   endtask : chk1

   task automatic chkg(input logic exp);
      @(negedge clk);
      chk32({31'h0, global_status}, {31'h0, exp});
   endtask : chkg

   task automatic wait_rdy;
      int n;
      n = 0;
      @(negedge clk);
      while (hreadyout !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 20)
         chk32({31'h0, hreadyout}, 32'h1);
      @(posedge clk);
   endtask : wait_rdy

   task automatic bus(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask : bus

   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr32

   task automatic rd32(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk32(r, exp);
   endtask : rd32

   task automatic ev(input logic [2:0] late, input logic [2:0] done,
      input logic [1:0] st);
      @(posedge clk);
      fire_late <= late;
      fire_done <= done;
      stamp_ev <= st;
      @(posedge clk);
      fire_late <= 3'h0;
      fire_done <= 3'h0;
      stamp_ev <= 2'h0;
   endtask : ev

   // unit strobe and response monitor
   always @(negedge clk)
   begin
      if (unit_wr === 1'b1)
      begin
         wr_cnt++;
         last_addr = unit_addr;
         last_wdata = unit_wdata;
      end
      if (unit_rd === 1'b1)
         rd_cnt++;
      if (rst_n && hresp !== ptp_unit_pkg::HRESP_OKAY)
         chk32({31'h0, hresp}, 32'h0);
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         conclude();
      end
   end

   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd32(ptp_unit_pkg::OFF_INDEX, 32'h0);
      rd32(ptp_unit_pkg::OFF_FIRE_STAT, 32'h0);
      rd32(ptp_unit_pkg::OFF_IRQ_STAT, 32'h0);
      wr32(ptp_unit_pkg::OFF_INDEX, 32'hffffffff);
      rd32(ptp_unit_pkg::OFF_INDEX, 32'h103);
      chk32({23'h0, stamp_sel, 6'h0, fire_sel}, 32'h103);
      rd32(ptp_unit_pkg::OFF_UNIT_CTRL, 32'h0);
      wr32(12'h5b0, 32'h5a5a5a5a);
      chk32(32'(wr_cnt + rd_cnt), 32'h0);
      wr32(ptp_unit_pkg::OFF_INDEX, 32'h1);
      wr32(12'h5b0, 32'h12345678);
      wr32(12'h5b4, 32'h87654321);
      chk32(32'(wr_cnt), 32'h1);
      chk32({20'h0, last_addr}, 32'h5b0);
      chk32(last_wdata, 32'h12345678);
      rd32(ptp_unit_pkg::OFF_UNIT_CTRL, 32'h0000c300);
      chk32(32'(rd_cnt), 32'h1);
      wr32(12'h600, 32'hffffffff);
      rd32(12'h600, 32'h0);
      for (int i = 0; i < 3; i++)
      begin
         ev(3'h0, 3'(1 << i), 2'h0);
         chkg(i < 2);
         rd32(ptp_unit_pkg::OFF_FIRE_STAT, i < 2 ? 32'(1 << i) : 0);
         rd32(ptp_unit_pkg::OFF_IRQ_STAT, i < 2 ? 32'(1 << (16 + i)) : 0);
         wr32(ptp_unit_pkg::OFF_FIRE_STAT, 32'hffffffff);
         wr32(ptp_unit_pkg::OFF_IRQ_STAT, 32'hffffffff);
         rd32(ptp_unit_pkg::OFF_FIRE_STAT, 32'h0);
         rd32(ptp_unit_pkg::OFF_IRQ_STAT, 32'h0);
      end
      ev(3'h4, 3'h0, 2'h0);
      rd32(ptp_unit_pkg::OFF_FIRE_STAT, 32'h0);
      @(posedge clk);
      fire_notify <= 3'h7;
      ev(3'h4, 3'h0, 2'h0);
      rd32(ptp_unit_pkg::OFF_FIRE_STAT, 32'h00040000);
      rd32(ptp_unit_pkg::OFF_IRQ_STAT, 32'h00040000);
      chk1(1'b0);
      wr32(ptp_unit_pkg::OFF_IRQ_MASK, 32'h00040000);
      chk1(1'b1);
      wr32(ptp_unit_pkg::OFF_UNIT_CTRL, 32'h0);
      rd32(ptp_unit_pkg::OFF_FIRE_STAT, 32'h00040000);
      wr32(ptp_unit_pkg::OFF_INDEX, 32'h2);
      wr32(ptp_unit_pkg::OFF_UNIT_CTRL, 32'h0);
      rd32(ptp_unit_pkg::OFF_FIRE_STAT, 32'h0);
      wr32(ptp_unit_pkg::OFF_IRQ_STAT, 32'h00040000);
      chk1(1'b0);
      chkg(1'b0);
      ev(3'h0, 3'h0, 2'h3);
      rd32(ptp_unit_pkg::OFF_IRQ_STAT, 32'h0);
      wr32(ptp_unit_pkg::OFF_INDEX, 32'h100);
      wr32(ptp_unit_pkg::OFF_UNIT_CTRL, 32'h20);
      rd32(ptp_unit_pkg::OFF_UNIT_CTRL, 32'h0000c320);
      ev(3'h0, 3'h0, 2'h3);
      rd32(ptp_unit_pkg::OFF_IRQ_STAT, 32'h2);
      chkg(1'b1);
      chk1(1'b0);
      wr32(ptp_unit_pkg::OFF_IRQ_MASK, 32'h2);
      chk1(1'b1);
      wr32(ptp_unit_pkg::OFF_IRQ_STAT, 32'h2);
      chk1(1'b0);
      chkg(1'b0);
      conclude();
   end
endmodule : ptp_unit_index_gpio_status_bench
`default_nettype wire
